// *** hdl/tfp_frame_pipe.sv ***
`timescale 1ns/1ps
// ====================================================================
// Overview of operation
// (R01) a whole frame of input bits is collected before processing starts
// (R02) framed mode aligns on the frame pulse, strobed mode on the strobes
// (R03) all channels are processed in the next frame, then outputs load
// (R04) output data leaves exactly two frames after its input arrived
// (R05) control channels and bypass data take the same two-frame path
// (R06) other side keeps at least 512 master clocks between strobe rises
// (R07) other side alternates the first and second channel strobes
// (R08) master clock gives at least 512 cycles in every frame
// (R09) extra master clocks per frame are fine; each frame realigns
// (R10) framed mode ignores strobes and uses a fixed 256-bit frame
// (R11) serial output is driven only inside assigned channel slots
module tfp_frame_pipe
    import tfp_pkg::*;
#(
    parameter int unsigned PROC_CYCLES = MIN_MCLK_PER_FRAME
) (
    // master clock domain
    input wire logic ref_clk,
    input wire logic sys_rst,
    // link clock and mode pin
    input wire logic link_clk,
    input wire logic framed_backplane_mode,
    // alignment pins
    input wire logic frame_pulse_in,
    input wire logic first_channel_strobe,
    input wire logic second_channel_strobe,
    // serial data
    input wire logic ser_in,
    output logic ser_out,
    output logic ser_out_en_n
);

    localparam int unsigned CW = $clog2(PROC_CYCLES + 1);
    localparam logic [CW-1:0] PROC_LAST = CW'(PROC_CYCLES - 1);
    localparam logic [CW-1:0] PCNT_ZERO = '0;

    // ================================================================
    // crossings between the link and master clock domains
    logic [6:0] link_s;
    logic rst_l, mode_s, fp_s, s1_s, s2_s, ser_s;
    logic done_tgl_ff, done_s;
    logic start_tgl_ff, start_s;

    tfp_sync #(.WIDTH(7)) u_link_sync (
        .clk(link_clk),
        .async_in({sys_rst, framed_backplane_mode, frame_pulse_in,
                   first_channel_strobe, second_channel_strobe, ser_in,
                   done_tgl_ff}),
        .sync_out(link_s)
    );
    assign {rst_l, mode_s, fp_s, s1_s, s2_s, ser_s, done_s} = link_s;

    tfp_sync #(.WIDTH(1)) u_start_sync (
        .clk(ref_clk),
        .async_in(start_tgl_ff),
        .sync_out(start_s)
    );

    // ================================================================
    // link domain: alignment and bit position
    logic fp_q_ff, s1_q_ff, s2_q_ff, done_q_ff;
    logic fp_rise, s1_rise, s2_rise, done_evt;
    logic frame_start, slot_start, active;
    logic [7:0] cnt_ff, pos;
    logic [1:0] slot;
    logic [2:0] bitn;

    // edge history, read only from synchronised levels; idle pins are low
    always_ff @(posedge link_clk)
    begin
        if (rst_l)
            {fp_q_ff, s1_q_ff, s2_q_ff, done_q_ff} <= '0;
        else
            {fp_q_ff, s1_q_ff, s2_q_ff, done_q_ff} <=
                {fp_s, s1_s, s2_s, done_s};
    end

    assign fp_rise = fp_s & ~fp_q_ff;
    assign s1_rise = s1_s & ~s1_q_ff;
    assign s2_rise = s2_s & ~s2_q_ff;
    assign done_evt = done_s ^ done_q_ff;

    // frame edge from pulse or first strobe; strobes unused when framed
    assign frame_start = mode_s ? fp_rise : s1_rise; // see R02, R10
    assign slot_start = mode_s ? fp_rise : (s1_rise | s2_rise);
    assign pos = slot_start ? POS_ZERO : cnt_ff;
    assign bitn = pos[2:0];
    assign active = mode_s ? (pos < FRAMED_SPAN)
                           : ((s1_s | s2_s) && (pos < STROBE_SPAN));
    assign slot = mode_s ? pos[4:3] : (s2_s ? SLOT_SECOND : SLOT_FIRST);

    // bit counter saturates, so a lost pulse silences the slots
    always_ff @(posedge link_clk)
    begin
        if (rst_l)
            cnt_ff <= POS_MAX;
        else if (pos != POS_MAX)
            cnt_ff <= pos + POS_ONE; // see R09
    end

    // ================================================================
    // link domain: three frame stages
    logic [6:0] shift_ff;
    logic [7:0] in_buf_ff [NUM_SLOTS];
    logic [7:0] proc_buf_ff [NUM_SLOTS];
    logic [7:0] result_buf_ff [NUM_SLOTS];
    logic [7:0] out_buf_ff [NUM_SLOTS];
    logic done_seen_ff;

    // input shift register fills a slot byte bit by bit
    always_ff @(posedge link_clk)
    begin
        if (rst_l)
            shift_ff <= '0;
        else if (active)
            shift_ff <= {shift_ff[5:0], ser_s};
    end

    // output stage only takes a frame whose processing ended
    logic [7:0] out_load [NUM_SLOTS];
    always_comb
    begin
        for (int i = 0; i < NUM_SLOTS; i++)
            out_load[i] = done_evt ? proc_buf_ff[i]
                : (done_seen_ff ? result_buf_ff[i] : IDLE_BYTE);
    end

    // every slot, control ones included, walks the same stages
    always_ff @(posedge link_clk)
    begin
        if (rst_l)
        begin
            for (int i = 0; i < NUM_SLOTS; i++)
            begin
                in_buf_ff[i] <= IDLE_BYTE;
                proc_buf_ff[i] <= IDLE_BYTE;
                result_buf_ff[i] <= IDLE_BYTE;
                out_buf_ff[i] <= IDLE_BYTE;
            end
        end
        else
        begin
            if (active && bitn == LAST_BIT)
                in_buf_ff[slot] <= {shift_ff, ser_s}; // see R01
            if (done_evt)
                result_buf_ff <= proc_buf_ff; // see R05
            if (frame_start)
            begin
                proc_buf_ff <= in_buf_ff; // see R01, R05
                out_buf_ff <= out_load; // see R03, R04
            end
        end
    end

    // done is consumed by the frame edge that uses it
    always_ff @(posedge link_clk)
    begin
        if (rst_l)
            done_seen_ff <= 1'b0;
        else if (frame_start)
            done_seen_ff <= 1'b0;
        else if (done_evt)
            done_seen_ff <= 1'b1;
    end

    // start toggle hands each new frame to the engine
    always_ff @(posedge link_clk)
    begin
        if (rst_l)
            start_tgl_ff <= 1'b0;
        else if (frame_start)
            start_tgl_ff <= ~start_tgl_ff; // see R03
    end

    // ================================================================
    // link domain: serial output, one link clock behind the position
    logic ser_out_ff, ser_en_n_ff;
    logic [7:0] out_byte;

    // the frame edge loads the output stage on the edge that sends its
    // first bit, so that bit must come from the value being loaded
    assign out_byte = frame_start ? out_load[slot] : out_buf_ff[slot];

    always_ff @(posedge link_clk)
    begin
        if (rst_l || !active)
        begin
            ser_out_ff <= 1'b0;
            ser_en_n_ff <= 1'b1; // see R11
        end
        else
        begin
            ser_out_ff <= out_byte[LAST_BIT - bitn]; // see R04
            ser_en_n_ff <= 1'b0; // see R11
        end
    end

    assign ser_out = ser_out_ff;
    assign ser_out_en_n = ser_en_n_ff;

    // ================================================================
    // master clock domain: processing engine
    tfp_proc_state_t state_ff;
    logic start_q_ff, start_evt;
    logic [CW-1:0] pcnt_ff;

    assign start_evt = start_s ^ start_q_ff;

    // a new frame always restarts the engine, early or late
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state_ff <= ST_IDLE;
            pcnt_ff <= PCNT_ZERO;
            start_q_ff <= 1'b0;
            done_tgl_ff <= 1'b0;
        end
        else
        begin
            start_q_ff <= start_s;
            case (state_ff)
                ST_IDLE:
                begin
                    if (start_evt)
                    begin
                        state_ff <= ST_BUSY; // see R09
                        pcnt_ff <= PCNT_ZERO;
                    end
                end
                ST_BUSY:
                begin
                    if (start_evt)
                        pcnt_ff <= PCNT_ZERO; // see R09
                    else if (pcnt_ff == PROC_LAST)
                    begin
                        state_ff <= ST_IDLE;
                        done_tgl_ff <= ~done_tgl_ff; // see R03
                    end
                    else
                        pcnt_ff <= pcnt_ff + 1'b1;
                end
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end

    // ================================================================
    // checks
    sequence s_last_count;
        state_ff == ST_BUSY && pcnt_ff == PROC_LAST && !start_evt;
    endsequence

    sequence s_done_step;
        state_ff == ST_IDLE && done_tgl_ff != $past(done_tgl_ff);
    endsequence

    a_proc_done: assert property ( // see R03
        @(posedge ref_clk) disable iff (sys_rst)
        s_last_count |=> s_done_step)
        else $error("engine did not finish on its last count");
    a_engine_realign: assert property ( // see R09
        @(posedge ref_clk) disable iff (sys_rst)
        start_evt |=> state_ff == ST_BUSY && pcnt_ff == PCNT_ZERO)
        else $error("engine did not restart on new frame");
    a_byte_capture: assert property ( // see R01
        @(posedge link_clk) disable iff (rst_l)
        active && bitn == LAST_BIT
        |=> in_buf_ff[$past(slot)] == {$past(shift_ff), $past(ser_s)})
        else $error("slot byte not captured");
    a_frame_align: assert property ( // see R02
        @(posedge link_clk) disable iff (rst_l)
        slot_start |=> cnt_ff == POS_ONE)
        else $error("bit position not realigned");
    a_out_load: assert property ( // see R04
        @(posedge link_clk) disable iff (rst_l)
        frame_start && done_seen_ff && !done_evt
        |=> out_buf_ff[0] == $past(result_buf_ff[0]))
        else $error("output stage not loaded with processed frame");
    a_ctl_stage: assert property ( // see R05
        @(posedge link_clk) disable iff (rst_l)
        frame_start |=> proc_buf_ff[1] == $past(in_buf_ff[1]))
        else $error("control slot skipped a stage");
    a_strobe_ignored: assert property ( // see R10
        @(posedge link_clk) disable iff (rst_l)
        mode_s && s1_rise && !fp_rise && cnt_ff != POS_MAX
        |-> !frame_start ##1 cnt_ff == $past(cnt_ff) + POS_ONE)
        else $error("strobe aligned a framed-mode frame");
    a_hiz_idle: assert property ( // see R11
        @(posedge link_clk) disable iff (rst_l)
        !active |=> ser_en_n_ff && !ser_out_ff)
        else $error("output driven outside its slot");

endmodule : tfp_frame_pipe

// *** hdl/tfp_pkg.sv ***
// ====================================================================
// shared constants of the frame pipeline
package tfp_pkg;

    // frame geometry
    localparam int unsigned SLOT_BITS = 8;
    localparam int unsigned NUM_SLOTS = 4;
    localparam int unsigned FRAMED_RATE_KBPS = 2048;
    localparam int unsigned FRAME_RATE_KHZ = 8;
    localparam int unsigned FRAME_BITS = FRAMED_RATE_KBPS / FRAME_RATE_KHZ;
    localparam int unsigned MIN_MCLK_PER_FRAME = 512;

    // bit position counter values
    localparam logic [7:0] POS_ZERO = 8'h00;
    localparam logic [7:0] POS_ONE = 8'h01;
    localparam logic [7:0] POS_MAX = 8'hff;
    localparam logic [7:0] FRAMED_SPAN = 8'h20;
    localparam logic [7:0] STROBE_SPAN = 8'h08;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // slot numbers used in strobed serial mode
    localparam logic [1:0] SLOT_FIRST = 2'h0;
    localparam logic [1:0] SLOT_SECOND = 2'h1;

    // byte sent when no processed frame is ready
    localparam logic [7:0] IDLE_BYTE = 8'hff;

    // processing engine states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } tfp_proc_state_t;

endpackage : tfp_pkg

// *** hdl/tfp_sync.sv ***
`timescale 1ns/1ps
// ====================================================================
// two flop synchroniser, one bit per lane
module tfp_sync #(
    parameter int unsigned WIDTH = 1
) (
    // destination clock
    input wire logic clk,
    // asynchronous levels
    input wire logic [WIDTH-1:0] async_in,
    // synchronised levels
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] stable_ff;

    // no reset here: the chain flushes itself within two edges
    always_ff @(posedge clk)
    begin
        meta_ff <= async_in;
        stable_ff <= meta_ff;
    end

    assign sync_out = stable_ff;

endmodule : tfp_sync

// *** sim/tfp_far_end.sv ***
`timescale 1ns/1ps
// ====================================================================
// far end model: codec or serial port feeding the pipeline
module tfp_far_end
    import tfp_pkg::*;
(
    // controls from the bench
    input wire logic link_clk,
    input wire logic run,
    input wire logic framed,
    input wire logic noise,
    // pins toward the block
    output logic frame_pulse_in = 1'b0,
    output logic first_channel_strobe = 1'b0,
    output logic second_channel_strobe = 1'b0,
    output logic ser_in = 1'b0,
    // bytes of the frame just started, slot 0 on top
    output logic [31:0] frame_word = 32'h0,
    output logic frame_start = 1'b0
);
    int unsigned pos_ff = 0;
    int unsigned len_ff = 1;
    logic [31:0] word_ff = 32'h0;

    // one bit per link clock, changed just after the edge
    always @(posedge link_clk)
    begin
        int unsigned p;
        int unsigned l;
        logic [31:0] w;
        p = run ? pos_ff : 0;
        w = (p == 0) ? $urandom : word_ff;
        // random gap keeps rises of each strobe at least 2070 ns apart
        l = (p == 0) ? (framed ? FRAME_BITS : 69 + $urandom_range(63, 0))
            : len_ff;
        frame_start <= run && p == 0;
        frame_word <= w;
        word_ff <= w;
        len_ff <= l;
        pos_ff <= (run && p + 1 < l) ? p + 1 : 0;
        frame_pulse_in <= run && framed && p == 0;
        // framed mode: strobes carry junk the block must ignore
        first_channel_strobe <= framed ? noise & 1'($urandom)
            : run && p < 8;
        second_channel_strobe <= framed ? noise & 1'($urandom)
            : run && p >= 16 && p < 24;
        if (run && p < 8)
            ser_in <= w[31 - p];
        else if (run && framed && p < 32)
            ser_in <= w[31 - p];
        else if (run && !framed && p >= 16 && p < 24)
            ser_in <= w[39 - p];
        else
            ser_in <= 1'($urandom); // released line keeps changing
    end
endmodule : tfp_far_end

// *** sim/tfp_frame_pipe_tb.sv ***
`timescale 1ns/1ps
// ====================================================================
// bench for the frame pipeline
module tfp_frame_pipe_tb;
    import tfp_pkg::*;

    logic ref_clk = 1'b0;
    logic link_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic framed = 1'b1;
    logic run = 1'b0;
    logic noise = 1'b0;
    logic frame_pulse_in, first_channel_strobe, second_channel_strobe;
    logic ser_in, ser_out, ser_out_en_n, frame_start;
    logic [31:0] frame_word;
    logic [7:0] exp_q[$];
    logic [7:0] shift = 8'h00;
    int bit_cnt = 0;
    int low_cnt = 0;
    int nfr = 0;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;

    // clocks: master 4 ns, link 30 ns, rising edges never coincide
    always #2 ref_clk = ~ref_clk;
    always #15 link_clk = ~link_clk;

    tfp_frame_pipe #(.PROC_CYCLES(16)) u_dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .link_clk(link_clk),
        .framed_backplane_mode(framed), .frame_pulse_in(frame_pulse_in),
        .first_channel_strobe(first_channel_strobe),
        .second_channel_strobe(second_channel_strobe),
        .ser_in(ser_in), .ser_out(ser_out), .ser_out_en_n(ser_out_en_n));

    tfp_far_end u_far (
        .link_clk(link_clk), .run(run), .framed(framed), .noise(noise),
        .frame_pulse_in(frame_pulse_in),
        .first_channel_strobe(first_channel_strobe),
        .second_channel_strobe(second_channel_strobe), .ser_in(ser_in),
        .frame_word(frame_word), .frame_start(frame_start));

    // ================================================================
    // helpers
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] want);
        check_count++;
        if (seen !== want)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask : check

    task automatic wrap_up();
        if (num_errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    // slots carried per frame in each mode
    function automatic int slots_of(input logic fr);
        return fr ? NUM_SLOTS : 2;
    endfunction : slots_of

    function automatic logic [7:0] slot_byte(input logic [31:0] w,
        input int s);
        return w[31 - 8 * s -: 8];
    endfunction : slot_byte

    // reset, pick the mode, expect two idle frames first
    task automatic do_reset(input logic fr);
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        framed <= fr;
        noise <= fr;
        repeat (32) @(posedge ref_clk);
        check("en_n in reset", ser_out_en_n, 1'b1);
        sys_rst <= 1'b0;
        exp_q.delete();
        repeat (2 * slots_of(fr)) exp_q.push_back(IDLE_BYTE);
        nfr = 0;
        low_cnt = 0;
        repeat (6) @(posedge link_clk);
    endtask : do_reset

    // stop after the slots of the last frame so no slot is cut short
    task automatic run_frames(input int n);
        @(posedge ref_clk);
        run <= 1'b1;
        repeat (n) @(posedge link_clk iff frame_start);
        repeat (40) @(posedge link_clk);
        @(posedge ref_clk);
        run <= 1'b0;
        repeat (300) @(posedge link_clk);
        check("frames held", exp_q.size(), 2 * slots_of(framed));
    endtask : run_frames

    // ================================================================
    // monitor: slot bits per frame, bytes matched two frames back
    always @(posedge link_clk)
    begin
        if (frame_start && !sys_rst)
        begin
            check("slot bits", low_cnt,
                nfr == 0 ? 0 : 8 * slots_of(framed));
            nfr++;
            low_cnt = 0;
            for (int s = 0; s < slots_of(framed); s++)
                exp_q.push_back(slot_byte(frame_word, s));
        end
        if (sys_rst)
            bit_cnt = 0;
        else if (ser_out_en_n === 1'b0)
        begin
            shift = {shift[6:0], ser_out};
            bit_cnt++;
            low_cnt++;
            if (bit_cnt == 8)
            begin
                bit_cnt = 0;
                check("byte", shift, exp_q.size() ? exp_q.pop_front()
                    : 8'hxx);
            end
        end
        else
            check("idle pins", {ser_out_en_n, ser_out}, 2'b10);
    end

    // watchdog on the master clock
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            num_errors++;
            wrap_up();
        end
    end

    // main sequence; a long idle gap precedes the last run
    initial
    begin
        void'($urandom(32'h1c0e));
        do_reset(1'b1);
        run_frames(6);
        do_reset(1'b0);
        run_frames(8);
        run_frames(3);
        wrap_up();
    end
endmodule : tfp_frame_pipe_tb
